// ---- verilog/clk_cfg_pkg.sv ----
// Constants and types shared by the clock configuration register block.
// Assumes an AXI4-Lite master with 16-bit byte addresses and 32-bit data.
package clk_cfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] OscCtlOff = 16'h1200;
  localparam logic [15:0] SpllOff = 16'h1220;
  localparam logic [15:0] Pb7Off = 16'h1360;
  localparam int unsigned NGen = 14;
  // Tuning, usb pll, four ref control/trim pairs, four peripheral dividers
  localparam logic [15:0] GenOff [NGen] = '{16'h1210, 16'h1230,
    16'h1280, 16'h1290, 16'h12a0, 16'h12b0, 16'h12c0, 16'h12d0,
    16'h12e0, 16'h12f0, 16'h1300, 16'h1310, 16'h1320, 16'h1330};
  localparam logic [31:0] GenMask [NGen] = '{32'h0000_003f, 32'h277f_0707,
    32'h7fff_ba0f, 32'hff80_0000, 32'h7fff_ba0f, 32'hff80_0000,
    32'h7fff_ba0f, 32'hff80_0000, 32'h7fff_ba0f, 32'hff80_0000,
    32'h0000_007f, 32'h0000_807f, 32'h0000_807f, 32'h0000_807f};
  localparam logic [31:0] GenRst [NGen] = '{32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0000_8801, 32'h0000_8801, 32'h0000_8801, 32'h0000_8801};
  localparam logic [31:0] Pb7Rst = 32'h0000_8801;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam logic [31:0] SpllMask = 32'h077f_0787;
  localparam logic [31:0] OscWrMask = 32'h0700_0701;
  localparam int unsigned OdivLsb = 24;
  localparam int unsigned MultLsb = 16;
  localparam int unsigned IdivLsb = 8;
  localparam int unsigned IclkBit = 7;
  localparam int unsigned RangeLsb = 0;
  localparam int unsigned FrcLsb = 24;
  localparam int unsigned NoscLsb = 8;
  localparam int unsigned OswenBit = 0;
  localparam int unsigned Cfg2OdivLsb = 16;
  localparam int unsigned Cfg2MultLsb = 8;
  localparam int unsigned Cfg2IclkBit = 7;
  localparam int unsigned Cfg2RangeLsb = 4;
  localparam int unsigned Cfg2IdivLsb = 0;
  localparam int unsigned Cfg1OscLsb = 0;
  localparam logic [2:0] CoscSpll = 3'h1;
  localparam logic [2:0] OdivMin = 3'h1;
  localparam logic [2:0] OdivMax = 3'h5;
  localparam logic [1:0] RespOkay = 2'h0;
  localparam logic [1:0] RespSlvErr = 2'h2;

  typedef enum logic [1:0] {StLoad = 2'b01, StRun = 2'b10} phase_e;

  typedef struct packed {
    logic [2:0] outDiv;
    logic [6:0] mult;
    logic [2:0] inDiv;
    logic inClk;
    logic [2:0] range;
  } system_pll_s;

endpackage

// ---- verilog/clk_cfg_regs.sv ----
// Clock unit configuration registers behind an AXI4-Lite slave.
// Assumes configuration words are stable and an unlock block drives writePermit.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module clk_cfg_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [15:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [15:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [31:0] cfgWord1,
  input wire logic [31:0] cfgWord2,
  input wire logic sysResetReq,
  input wire logic writePermit,
  output var clk_cfg_pkg::system_pll_s spllCfg,
  output logic [5:0] pllDivideRatio,
  output logic [7:0] pllMultiplyFactor,
  output logic pllDivReserved,
  output logic [2:0] currentOsc
);

  // ----------------------------------------------------------------
  // Bus handshake state
  // ----------------------------------------------------------------
  logic awFull_r, wFull_r, bValid_r, awReady_r, wReady_r;
  logic arReady_r, rValid_r;
  logic [1:0] bResp_r, rResp_r;
  logic [15:0] awAddr_r;
  logic [31:0] wData_r, rData_r;
  logic [3:0] wStrb_r;
  clk_cfg_pkg::phase_e phase_r;
  logic wasPor_r;
  clk_cfg_pkg::system_pll_s system_pll_r;
  logic [2:0] frc_r, current_osc_source_r, nosc_r;
  logic oswen_r;
  logic [5:0] divRatio_r;
  logic [7:0] mulFactor_r;
  logic divRes_r;
  logic [31:0] gen_r [clk_cfg_pkg::NGen];

  wire logic awTake = awvalid & awReady_r;
  wire logic wTake = wvalid & wReady_r;
  wire logic arTake = arvalid & arReady_r;
  wire logic doWrite = awFull_r & wFull_r & ~bValid_r;
  wire logic running = (phase_r == clk_cfg_pkg::StRun) & ~sysResetReq;
  // Ready flags are registered but fed from next-state terms, so a channel
  // reopens on the same edge its slot frees, with flop-driven outputs.
  wire logic awFull_nxt = (awFull_r | awTake) & ~doWrite;
  wire logic wFull_nxt = (wFull_r | wTake) & ~doWrite;
  wire logic bValid_nxt = doWrite | (bValid_r & ~bready);
  wire logic awReady_nxt = ~awFull_nxt & ~bValid_nxt & running;
  wire logic wReady_nxt = ~wFull_nxt & ~bValid_nxt & running;
  wire logic rValid_nxt = arTake | (rValid_r & ~rready);
  wire logic arReady_nxt = ~rValid_nxt;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic [31:0] byteMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}},
                                {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
  wire logic wrOsc = awAddr_r[15:2] == clk_cfg_pkg::OscCtlOff[15:2];
  wire logic wrSpll = awAddr_r[15:2] == clk_cfg_pkg::SpllOff[15:2];
  wire logic wrPb7 = awAddr_r[15:2] == clk_cfg_pkg::Pb7Off[15:2];
  wire logic rdOsc = araddr[15:2] == clk_cfg_pkg::OscCtlOff[15:2];
  wire logic rdSpll = araddr[15:2] == clk_cfg_pkg::SpllOff[15:2];
  wire logic rdPb7 = araddr[15:2] == clk_cfg_pkg::Pb7Off[15:2];
  logic [clk_cfg_pkg::NGen-1:0] wrGen, rdGen;
  wire logic wrHit = wrOsc | wrSpll | wrPb7 | (|wrGen);
  wire logic rdHit = rdOsc | rdSpll | rdPb7 | (|rdGen);

  // ----------------------------------------------------------------
  // Packed register images
  // ----------------------------------------------------------------
  // Unimplemented positions are constant zero in the image
  wire logic [31:0] spllWord = {5'h0, system_pll_r.outDiv, 1'b0, system_pll_r.mult,
    5'h0, system_pll_r.inDiv, system_pll_r.inClk, 4'h0, system_pll_r.range};
  wire logic [31:0] oscWord = {5'h0, frc_r, 9'h0, current_osc_source_r, 1'b0, nosc_r,
    7'h0, oswen_r};
  wire logic [31:0] spllWm = clk_cfg_pkg::SpllMask & byteMask;
  wire logic [31:0] spllNew = (spllWord & ~spllWm) | (wData_r & spllWm);
  wire logic [31:0] oscWm = clk_cfg_pkg::OscWrMask & byteMask;
  wire logic [31:0] oscNew = (oscWord & ~oscWm) | (wData_r & oscWm);
  // Retuning the pll while it clocks the system would glitch the core,
  // so such writes are dropped rather than queued.
  wire logic spllLocked = current_osc_source_r == clk_cfg_pkg::CoscSpll;
  // Write permit comes from the unlock block
  wire logic spllWrOk = doWrite & wrSpll & writePermit & ~spllLocked;
  wire logic oscWrOk = doWrite & wrOsc & writePermit;

  clk_cfg_pkg::system_pll_s spllNewS, cfgSpll;
  assign spllNewS.outDiv = spllNew[clk_cfg_pkg::OdivLsb +: 3];
  assign spllNewS.mult = spllNew[clk_cfg_pkg::MultLsb +: 7];
  assign spllNewS.inDiv = spllNew[clk_cfg_pkg::IdivLsb +: 3];
  assign spllNewS.inClk = spllNew[clk_cfg_pkg::IclkBit];
  assign spllNewS.range = spllNew[clk_cfg_pkg::RangeLsb +: 3];
  assign cfgSpll.outDiv = cfgWord2[clk_cfg_pkg::Cfg2OdivLsb +: 3];
  assign cfgSpll.mult = cfgWord2[clk_cfg_pkg::Cfg2MultLsb +: 7];
  assign cfgSpll.inDiv = cfgWord2[clk_cfg_pkg::Cfg2IdivLsb +: 3];
  assign cfgSpll.inClk = cfgWord2[clk_cfg_pkg::Cfg2IclkBit];
  assign cfgSpll.range = cfgWord2[clk_cfg_pkg::Cfg2RangeLsb +: 3];
  wire logic [2:0] cfgOsc = cfgWord1[clk_cfg_pkg::Cfg1OscLsb +: 3];
  // Reserved divider codes are stored as written; only the decode flags them
  wire logic odivOk = (system_pll_r.outDiv >= clk_cfg_pkg::OdivMin) &&
                      (system_pll_r.outDiv <= clk_cfg_pkg::OdivMax);

  // ----------------------------------------------------------------
  // Plain storage registers
  // ----------------------------------------------------------------
  // Bits outside each write mask keep their reset value, so ready flags
  // and fixed fields read back without extra logic.
  for (genvar i = 0; i < clk_cfg_pkg::NGen; i++) begin : g_reg
    assign wrGen[i] = awAddr_r[15:2] == clk_cfg_pkg::GenOff[i][15:2];
    assign rdGen[i] = araddr[15:2] == clk_cfg_pkg::GenOff[i][15:2];
    wire logic [31:0] wm = clk_cfg_pkg::GenMask[i] & byteMask;
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        gen_r[i] <= clk_cfg_pkg::GenRst[i];
      end else if (ce) begin
        if (sysResetReq) begin
          gen_r[i] <= clk_cfg_pkg::GenRst[i];
        end else if (doWrite && wrGen[i]) begin
          gen_r[i] <= (gen_r[i] & ~wm) | (wData_r & wm);
        end
      end
    end
  end

  // Address decodes are disjoint, so the order of the tests never matters
  logic [31:0] rdWord;
  always_comb begin
    rdWord = 32'h0;
    if (rdOsc) rdWord = oscWord;
    if (rdSpll) rdWord = spllWord;
    if (rdPb7) rdWord = clk_cfg_pkg::Pb7Rst;
    for (int i = 0; i < clk_cfg_pkg::NGen; i++) begin
      if (rdGen[i]) rdWord = gen_r[i];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write and read channels
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awFull_r <= 1'b0;
      wFull_r <= 1'b0;
      bValid_r <= 1'b0;
      awReady_r <= 1'b0;
      wReady_r <= 1'b0;
      bResp_r <= clk_cfg_pkg::RespOkay;
      awAddr_r <= 16'h0;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
    end else if (ce) begin
      awFull_r <= awFull_nxt;
      wFull_r <= wFull_nxt;
      bValid_r <= bValid_nxt;
      awReady_r <= awReady_nxt;
      wReady_r <= wReady_nxt;
      if (awTake) awAddr_r <= awaddr;
      if (wTake) wData_r <= wdata;
      if (wTake) wStrb_r <= wstrb;
      // A refused pll write still answers OKAY; the block only drops it
      if (doWrite) bResp_r <= wrHit ? clk_cfg_pkg::RespOkay : clk_cfg_pkg::RespSlvErr;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arReady_r <= 1'b0;
      rValid_r <= 1'b0;
      rData_r <= 32'h0;
      rResp_r <= clk_cfg_pkg::RespOkay;
    end else if (ce) begin
      arReady_r <= arReady_nxt;
      rValid_r <= rValid_nxt;
      if (arTake) rData_r <= rdWord;
      if (arTake) rResp_r <= rdHit ? clk_cfg_pkg::RespOkay : clk_cfg_pkg::RespSlvErr;
    end
  end

  // ----------------------------------------------------------------
  // Reset load, system pll and oscillator control
  // ----------------------------------------------------------------
  // Async reset takes constants only; config words are caught one enabled
  // edge after release, in the load phase.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_r <= clk_cfg_pkg::StLoad;
      wasPor_r <= 1'b1;
      system_pll_r <= '0;
      frc_r <= 3'h0;
      current_osc_source_r <= 3'h0;
      nosc_r <= 3'h0;
      oswen_r <= 1'b0;
    end else if (ce) begin
      if (sysResetReq) begin
        phase_r <= clk_cfg_pkg::StLoad;
        wasPor_r <= 1'b0;
      end else begin
        case (phase_r)
          clk_cfg_pkg::StLoad: begin
            phase_r <= clk_cfg_pkg::StRun;
            // Pll settings reload only on power-on; source on every reset
            if (wasPor_r) system_pll_r <= cfgSpll;
            if (wasPor_r) frc_r <= 3'h0;
            current_osc_source_r <= cfgOsc;
            nosc_r <= cfgOsc;
            oswen_r <= 1'b0;
          end
          clk_cfg_pkg::StRun: begin
            if (spllWrOk) system_pll_r <= spllNewS;
            if (oscWrOk) frc_r <= oscNew[clk_cfg_pkg::FrcLsb +: 3];
            if (oscWrOk) nosc_r <= oscNew[clk_cfg_pkg::NoscLsb +: 3];
            if (oswen_r) current_osc_source_r <= nosc_r;
            // Switch request self-clears; a new request in that cycle wins
            oswen_r <= oscWrOk & oscNew[clk_cfg_pkg::OswenBit];
          end
          default: phase_r <= clk_cfg_pkg::StLoad;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Decoded pll settings
  // ----------------------------------------------------------------
  // One extra cycle of latency keeps the decoded outputs on flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      divRatio_r <= 6'h0;
      mulFactor_r <= 8'h01;
      divRes_r <= 1'b1;
    end else if (ce) begin
      divRatio_r <= odivOk ? (6'h01 << system_pll_r.outDiv) : 6'h0;
      divRes_r <= ~odivOk;
      mulFactor_r <= {1'b0, system_pll_r.mult} + 8'h01;
    end
  end

  assign awready = awReady_r;
  assign wready = wReady_r;
  assign bvalid = bValid_r;
  assign bresp = bResp_r;
  assign arready = arReady_r;
  assign rvalid = rValid_r;
  assign rdata = rData_r;
  assign rresp = rResp_r;
  assign spllCfg = system_pll_r;
  assign pllDivideRatio = divRatio_r;
  assign pllMultiplyFactor = mulFactor_r;
  assign pllDivReserved = divRes_r;
  assign currentOsc = current_osc_source_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Helpers give the checks one-cycle views of internal conditions
  wire logic loadPor = ce & ~sysResetReq & (phase_r == clk_cfg_pkg::StLoad) & wasPor_r;
  wire logic loadSys = ce & ~sysResetReq & (phase_r == clk_cfg_pkg::StLoad) & ~wasPor_r;
  wire logic [2:0] pastOdivCfg = cfgSpll.outDiv;
  wire logic [6:0] pastMultCfg = cfgSpll.mult;
  wire logic [2:0] curOdiv = system_pll_r.outDiv;
  wire logic [2:0] wrIdiv = wData_r[clk_cfg_pkg::IdivLsb +: 3];

  chk_odiv_decode: assert property (@(posedge clk) disable iff (!nrst)
    ce |=> (pllDivideRatio == ((($past(curOdiv) >= 3'h1) && ($past(curOdiv) <= 3'h5))
      ? (6'h01 << $past(curOdiv)) : 6'h0)))
    else $error("output divider decode wrong");
  chk_mult_factor: assert property (@(posedge clk) disable iff (!nrst)
    ce |=> pllMultiplyFactor == {1'b0, $past(spllCfg.mult)} + 8'h01)
    else $error("multiplier factor wrong");
  chk_por_odiv: assert property (@(posedge clk) disable iff (!nrst)
    loadPor |=> spllCfg.outDiv == $past(pastOdivCfg))
    else $error("output divider default not loaded");
  chk_por_mult: assert property (@(posedge clk) disable iff (!nrst)
    loadPor |=> spllCfg.mult == $past(pastMultCfg))
    else $error("multiplier default not loaded");
  chk_por_whole: assert property (@(posedge clk) disable iff (!nrst)
    loadPor |=> spllCfg == $past(cfgSpll))
    else $error("pll fields not loaded at power-on");
  chk_unlock_gate: assert property (@(posedge clk) disable iff (!nrst)
    ce && doWrite && wrSpll && !writePermit |=> $stable(spllCfg))
    else $error("locked pll write took effect");
  chk_source_lock: assert property (@(posedge clk) disable iff (!nrst)
    ce && doWrite && wrSpll && spllLocked |=> $stable(spllCfg))
    else $error("pll write while pll is source");
  chk_system_pll_zeros: assert property (@(posedge clk) disable iff (!nrst)
    ce && arTake && rdSpll |=> (rdata & ~clk_cfg_pkg::SpllMask) == 32'h0)
    else $error("unimplemented pll bits not zero");
  chk_pb7_fixed: assert property (@(posedge clk) disable iff (!nrst)
    ce && arTake && rdPb7 |=> rdata == clk_cfg_pkg::Pb7Rst && rvalid)
    else $error("seventh divider not fixed");
  chk_reset_kind: assert property (@(posedge clk) disable iff (!nrst)
    loadSys |=> $stable(spllCfg) && currentOsc == $past(cfgOsc))
    else $error("reset kind handling wrong");
  chk_plain_store: assert property (@(posedge clk) disable iff (!nrst)
    ce && running && spllWrOk && wStrb_r[1] |=> spllCfg.inDiv == $past(wrIdiv))
    else $error("input divider not stored");
  chk_write_resp: assert property (@(posedge clk) disable iff (!nrst)
    ce && doWrite |=> bvalid ##0 !awready [*1])
    else $error("write response missing");

  // ----------------------------------------------------------------
  // Bus protocol checks
  // ----------------------------------------------------------------
  chk_aw_accept: assert property (@(posedge clk) disable iff (!nrst)
    ce && awTake && wTake |=> !awready && !wready)
    else $error("write channels not closed after accept");
  chk_resp_retire: assert property (@(posedge clk) disable iff (!nrst)
    ce && bvalid && bready |=> !bvalid)
    else $error("write response not retired");
  chk_write_err: assert property (@(posedge clk) disable iff (!nrst)
    ce && doWrite && !wrHit |=> bresp == clk_cfg_pkg::RespSlvErr)
    else $error("unmapped write not refused");
  chk_read_answer: assert property (@(posedge clk) disable iff (!nrst)
    ce && arTake |=> rvalid && !arready)
    else $error("read answer missing");
  chk_read_retire: assert property (@(posedge clk) disable iff (!nrst)
    ce && rvalid && rready |=> !rvalid)
    else $error("read answer not retired");
  chk_read_err: assert property (@(posedge clk) disable iff (!nrst)
    ce && arTake && !rdHit |=> rresp == clk_cfg_pkg::RespSlvErr && rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_ready_idle: assert property (@(posedge clk) disable iff (!nrst)
    ce && !running |=> !awready && !wready)
    else $error("write accepted outside run phase");

  // ----------------------------------------------------------------
  // Divider flag, oscillator and load checks
  // ----------------------------------------------------------------
  chk_div_flag: assert property (@(posedge clk) disable iff (!nrst)
    ce |=> pllDivReserved == (($past(curOdiv) < clk_cfg_pkg::OdivMin) ||
      ($past(curOdiv) > clk_cfg_pkg::OdivMax)))
    else $error("reserved divider flag wrong");
  chk_load_step: assert property (@(posedge clk) disable iff (!nrst)
    ce && !sysResetReq && phase_r == clk_cfg_pkg::StLoad |=> phase_r == clk_cfg_pkg::StRun)
    else $error("load phase did not end");
  chk_osc_switch: assert property (@(posedge clk) disable iff (!nrst)
    ce && running && oswen_r |=> currentOsc == $past(nosc_r))
    else $error("source switch not applied");
  chk_switch_clear: assert property (@(posedge clk) disable iff (!nrst)
    ce && running && oswen_r && !oscWrOk |=> !oswen_r)
    else $error("switch request did not clear");

endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the clock configuration register block.
// Assumes the block answers on AXI4-Lite and that ce may stay high throughout.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [15:0] awaddr = 16'h0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b1;
  logic [15:0] araddr = 16'h0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b1;
  logic [31:0] cfgWord1 = 32'h0;
  logic [31:0] cfgWord2 = 32'h0003_45d2;
  logic sysResetReq = 1'b0;
  logic writePermit = 1'b0;
  clk_cfg_pkg::system_pll_s spllCfg;
  logic [5:0] pllDivideRatio;
  logic [7:0] pllMultiplyFactor;
  logic pllDivReserved;
  logic [2:0] currentOsc;
  int failures = 0;
  int n_tests = 0;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [6:0] m;

  always #4 clk = ~clk;

  clk_cfg_regs DUT (.clk(clk), .nrst(nrst), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .cfgWord1(cfgWord1), .cfgWord2(cfgWord2), .sysResetReq(sysResetReq),
    .writePermit(writePermit), .spllCfg(spllCfg), .pllDivideRatio(pllDivideRatio),
    .pllMultiplyFactor(pllMultiplyFactor), .pllDivReserved(pllDivReserved),
    .currentOsc(currentOsc));

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; handshakes are judged mid-cycle, so
  // the sample never races the edge that moves the item.
  task automatic axWrite(input logic [15:0] a, input logic [31:0] d,
                         output logic [1:0] resp);
    logic aDone, wDone, bDone, aNow, wNow, bNow;
    aDone = 1'b0;
    wDone = 1'b0;
    bDone = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!bDone) begin
      @(negedge clk);
      aNow = awvalid & awready;
      wNow = wvalid & wready;
      bNow = bvalid;
      resp = bresp;
      @(posedge clk);
      if (aNow) awvalid <= 1'b0;
      if (wNow) wvalid <= 1'b0;
      bDone = bNow;
    end
  endtask

  task automatic axRead(input logic [15:0] a, output logic [31:0] d,
                        output logic [1:0] resp);
    logic rDone, arNow, rNow;
    rDone = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!rDone) begin
      @(negedge clk);
      arNow = arvalid & arready;
      rNow = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge clk);
      if (arNow) arvalid <= 1'b0;
      rDone = rNow;
    end
  endtask

  task automatic summarize();
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    axRead(clk_cfg_pkg::SpllOff, rd, rsp);
    check(rd, 32'h0345_0285);
    check({16'h0, spllCfg}, {16'h0, 3'h3, 7'h45, 3'h2, 1'b1, 3'h5});
    check({26'h0, pllDivideRatio}, 32'h8);
    check({24'h0, pllMultiplyFactor}, 32'h46);
    axWrite(clk_cfg_pkg::SpllOff, 32'hffff_ffff, rsp);
    axRead(clk_cfg_pkg::SpllOff, rd, rsp);
    check(rd, 32'h0345_0285);
    writePermit <= 1'b1;
    axWrite(clk_cfg_pkg::SpllOff, 32'hffff_ffff, rsp);
    axRead(clk_cfg_pkg::SpllOff, rd, rsp);
    check(rd, 32'h077f_0787);
    // Sweep runs while the pll is not the clock source, so no live node leaves range
    for (int c = 0; c < 8; c++) begin
      m = (c == 7) ? 7'h7f : 7'(c * 18);
      axWrite(clk_cfg_pkg::SpllOff, {5'h0, 3'(c), 1'b0, m, 16'h0}, rsp);
      repeat (2) @(posedge clk);
      check({26'h0, pllDivideRatio}, (c >= 1 && c <= 5) ? 32'h1 << c : 32'h0);
      check({31'h0, pllDivReserved}, (c >= 1 && c <= 5) ? 32'h0 : 32'h1);
      check({24'h0, pllMultiplyFactor}, {24'h0, 1'b0, m} + 32'h1);
    end
    axWrite(clk_cfg_pkg::Pb7Off, 32'h0000_0000, rsp);
    check({30'h0, rsp}, {30'h0, clk_cfg_pkg::RespOkay});
    axRead(clk_cfg_pkg::Pb7Off, rd, rsp);
    check(rd, 32'h0000_8801);
    axRead(16'h1400, rd, rsp);
    check({rd[31:2], rsp}, {30'h0, clk_cfg_pkg::RespSlvErr});
    axWrite(16'h1404, 32'h1, rsp);
    check({30'h0, rsp}, {30'h0, clk_cfg_pkg::RespSlvErr});
    axWrite(16'h1300, 32'h0000_0005, rsp);
    axRead(16'h1300, rd, rsp);
    check(rd, 32'h0000_8805);
    // Switch the current source onto the system pll, then try to retune it
    axWrite(clk_cfg_pkg::OscCtlOff, 32'h0000_0101, rsp);
    repeat (2) @(posedge clk);
    check({29'h0, currentOsc}, {29'h0, clk_cfg_pkg::CoscSpll});
    axWrite(clk_cfg_pkg::SpllOff, 32'h0000_0000, rsp);
    axRead(clk_cfg_pkg::SpllOff, rd, rsp);
    check(rd, 32'h077f_0000);
    cfgWord1 <= 32'h0000_0002;
    sysResetReq <= 1'b1;
    @(posedge clk);
    sysResetReq <= 1'b0;
    repeat (4) @(posedge clk);
    check({29'h0, currentOsc}, 32'h2);
    axRead(16'h1300, rd, rsp);
    check(rd, 32'h0000_8801);
    axRead(clk_cfg_pkg::SpllOff, rd, rsp);
    check(rd, 32'h077f_0000);
    summarize();
  end
endmodule
`default_nettype wire
